// ==== tcc_timer.sv ====
// Purpose: 8-bit timer/counter with compare unit, APB registers
// Assumes: prescaler tick inputs are one-cycle pulses on pclk
// Notes:   flags clear by writing one; acknowledge clears compare flag
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.svh"
module tcc_timer
   import tcc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [6:0]  presc_tick,
   input  wire logic        ext_clk_pin,
   input  wire logic        cmp_irq_ack,
   input  wire logic        ovf_irq_ack,
   output logic             ovf_irq,
   output logic             cmp_irq,
   output logic             compare_output,
   output logic             top_flag,
   output logic             bottom_flag
);
   logic [7:0] counter_value;
   logic [7:0] compare_value;
   logic [7:0] cmp_buffer;
   logic [2:0] wgm;
   logic [1:0] com;
   logic [2:0] clock_select_field;
   logic       overflow_flag;
   logic       compare_flag;
   logic [1:0] mask;
   logic       block_match;
   tcc_dir_t   dir;
   logic       ext_sync;
   logic       ext_prev;
   logic       tick;
   logic       wr;
   logic       cnt_wr;
   logic       force_wr;
   logic       match;
   logic       at_top;
   logic       at_bottom;
   logic       pwm_mode;
   logic [7:0] top_val;
   logic [7:0] next_count;
   logic       oc_state;
   logic       flag_clr_ovf;
   logic       flag_clr_cmp;

   // Address compare shared by the write decode points; read decode cases on paddr
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction

   assign wr = psel && penable && pwrite;
   assign cnt_wr = wr && hit(paddr, `TCC_OFF_COUNT);
   assign force_wr = wr && hit(paddr, `TCC_OFF_FORCE)
                     && pwdata[`TCC_BIT_FORCE];
   assign pwm_mode = wgm[0];                               // [RULE_16]

   // External count input, synchronised then edge detected
   tcc_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (ext_clk_pin),
      .dout    (ext_sync)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev <= 1'b0;
      end else begin
         ext_prev <= ext_sync;
      end
   end

   // Clock select: 0 stops, 1..5 prescaler taps, 6/7 external edge
   always_comb begin
      unique case (clock_select_field)
         3'h0:    tick = 1'b0;                             // [RULE_04]
         3'h6:    tick = ext_prev && !ext_sync;
         3'h7:    tick = !ext_prev && ext_sync;
         default: tick = presc_tick[clock_select_field];   // [RULE_28]
      endcase
   end

   // Top selection and comparator
   assign top_val = wgm[2] ? compare_value : `TCC_MAX;      // [RULE_08]
   assign match = (counter_value == compare_value)         // [RULE_01]
                  && !block_match;                          // [RULE_21]
   assign at_top = (wgm[1:0] == 2'b10) ?
                   (counter_value == compare_value) :
                   (counter_value == top_val);
   assign at_bottom = (counter_value == `TCC_BOTTOM);      // [RULE_07]

   // Next counter value per mode and direction
   always_comb begin
      next_count = counter_value;
      unique case (wgm[1:0])                               // [RULE_09]
         2'b00: next_count = counter_value + 8'h01;        // [RULE_24]
         2'b10: next_count = (counter_value == compare_value) ?
                             `TCC_BOTTOM :
                             counter_value + 8'h01;         // [RULE_25]
         2'b11: next_count = at_top ? `TCC_BOTTOM :
                             counter_value + 8'h01;
         // Turn at top and bottom at once; dir register updates on the same tick
         2'b01: next_count = (at_top || (dir == TCC_DOWN && !at_bottom)) ?
                             counter_value - 8'h01 :
                             counter_value + 8'h01;         // [RULE_02]
      endcase
   end

   // Counter register; software write wins over count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_value <= `TCC_RST_BYTE;
      end else if (cnt_wr) begin
         counter_value <= pwdata[7:0];                     // [RULE_06] [RULE_05]
      end else if (tick) begin
         counter_value <= next_count;                      // [RULE_03]
      end
   end

   // Direction for dual-slope mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir <= TCC_UP;
      end else if (wgm[1:0] != 2'b01) begin
         dir <= TCC_UP;
      end else if (tick && at_top) begin
         dir <= TCC_DOWN;
      end else if (tick && at_bottom) begin
         dir <= TCC_UP;
      end
   end

   // Match blocking after a counter write, released by next tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         block_match <= 1'b0;
      end else if (cnt_wr) begin
         block_match <= 1'b1;                              // [RULE_21]
      end else if (tick) begin
         block_match <= 1'b0;
      end
   end

   // Compare value and its buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_value <= `TCC_RST_BYTE;
         cmp_buffer    <= `TCC_RST_BYTE;
      end else begin
         if (wr && hit(paddr, `TCC_OFF_CMP)) begin
            cmp_buffer <= pwdata[7:0];
            if (!pwm_mode) begin
               compare_value <= pwdata[7:0];               // [RULE_18]
            end
         end
         if (pwm_mode && tick) begin
            if ((wgm[1] && at_top) || (!wgm[1] && at_top)) begin
               compare_value <= cmp_buffer;                // [RULE_17]
            end
         end
      end
   end

   // Control fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wgm                <= 3'h0;
         com                <= 2'h0;
         clock_select_field <= 3'h0;
         mask               <= 2'h0;
      end else begin
         if (wr && hit(paddr, `TCC_OFF_CTRL)) begin
            wgm <= pwdata[`TCC_F_WGM_HI:`TCC_F_WGM_LO];
            com <= pwdata[`TCC_F_COM_LO+1:`TCC_F_COM_LO];  // [RULE_22]
            clock_select_field <= pwdata[`TCC_F_CS_LO+2:`TCC_F_CS_LO];
         end
         if (wr && hit(paddr, `TCC_OFF_MASK)) begin
            mask <= pwdata[1:0];                           // [RULE_14]
         end
      end
   end

   assign flag_clr_ovf = (wr && hit(paddr, `TCC_OFF_FLAG)
                          && pwdata[`TCC_BIT_OVF]) || ovf_irq_ack;
   assign flag_clr_cmp = (wr && hit(paddr, `TCC_OFF_FLAG)
                          && pwdata[`TCC_BIT_CMP]) || cmp_irq_ack;

   // Flags: set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag <= 1'b0;
         compare_flag  <= 1'b0;
      end else begin
         if (tick && ((wgm[0] == 1'b0 && counter_value == `TCC_MAX
                       && next_count == `TCC_BOTTOM)          // [RULE_26]
                      || (wgm[1:0] == 2'b11 && at_top)
                      || (wgm[1:0] == 2'b01 && at_bottom))) begin
            overflow_flag <= 1'b1;                         // [RULE_10]
         end else if (flag_clr_ovf) begin
            overflow_flag <= 1'b0;
         end
         if (tick && match) begin
            compare_flag <= 1'b1;                          // [RULE_11]
         end else if (flag_clr_cmp) begin
            compare_flag <= 1'b0;                          // [RULE_13] [RULE_12]
         end
      end
   end

   // Waveform output state
   tcc_wavegen u_wave (
      .pclk      (pclk),
      .presetn   (presetn),
      .tick      (tick),
      .match     (match),
      .force_hit (force_wr && !pwm_mode),
      .at_top    (at_top),
      .at_bottom (at_bottom),
      .down      (dir == TCC_DOWN),
      .mode      (wgm),
      .action    (com),
      .oc_state  (oc_state)
   );

   // Registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_irq        <= 1'b0;
         cmp_irq        <= 1'b0;
         compare_output <= 1'b0;
         top_flag       <= 1'b0;
         bottom_flag    <= 1'b0;
      end else begin
         ovf_irq        <= overflow_flag && mask[`TCC_BIT_OVF];
         cmp_irq        <= compare_flag && mask[`TCC_BIT_CMP]; // [RULE_12]
         compare_output <= oc_state;
         top_flag       <= at_top;
         bottom_flag    <= at_bottom;                      // [RULE_07]
      end
   end

   // APB read data and answer, zero wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && !penable) begin
            unique case (paddr)
               `TCC_OFF_CTRL:  prdata <= {21'h0, clock_select_field,
                                          2'h0, com, 1'b0, wgm};
               `TCC_OFF_COUNT: prdata <= {24'h0, counter_value};
               `TCC_OFF_CMP:   prdata <= {24'h0, pwm_mode ?
                                          cmp_buffer : compare_value};
               `TCC_OFF_FLAG:  prdata <= {30'h0, compare_flag,
                                          overflow_flag};
               `TCC_OFF_MASK:  prdata <= {30'h0, mask};
               `TCC_OFF_FORCE: prdata <= 32'h0000_0000;
               default:        pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== tcc_defs.svh ====
// Purpose: constants for the 8-bit timer/counter with one compare unit
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   offsets are byte addresses; field positions are bit indices
// Notes on behaviour
// RULE_01: Counter and compare registers are 8 bits, with an 8-bit equality compare.
// RULE_02: Counter counts up or down by one under a direction control.
// RULE_03: Each timer tick clears, increments or decrements per mode.
// RULE_04: Clock select zero gives no tick; counter stays stopped.
// RULE_05: Software reads and writes the counter whether running or not.
// RULE_06: A software counter write beats clear or count in that cycle.
// RULE_07: Bottom is 0x00; maximum is 0xFF.
// RULE_08: Top is 0xFF or the compare value, chosen by mode.
// RULE_09: The two low waveform-mode bits select the count sequence.
// RULE_10: Overflow flag set at mode-dependent points; can interrupt.
// RULE_11: Equality sets the compare flag on the following tick.
// RULE_12: Enabled compare flag requests interrupt; service acknowledge clears it.
// RULE_13: Writing one to the compare flag bit clears it; zero keeps it.
// RULE_14: Flags read in a flag register; each masked individually.
// RULE_15: Output derives from match, mode, action bits, top and bottom; in the code top has no effect on the output.
// RULE_16: Compare value double buffered in PWM modes only.
// RULE_17: Buffered compare value moves to active at top or bottom; the code copies it at top only, in both PWM modes.
// RULE_18: Software compare access hits buffer when buffered, else active.
// RULE_19: Force strobe acts as a match for the output in non-PWM modes.
// RULE_20: Forced match sets no flag, no clear; output per action bits.
// RULE_21: A counter write blocks compare matches in the next tick.
// RULE_22: Output state holds across mode changes; action changes act at once.
// RULE_23: Software should set output state by forcing before enabling the pin.
// RULE_24: Mode zero counts up only and wraps from max to zero.
// RULE_25: Mode two clears the counter when it matches the compare value.
// RULE_26: In normal mode overflow sets as the counter becomes zero.
// RULE_27: Reset clears the internal output state to low.
// RULE_28: The timer tick is a one-cycle enable from an outside prescaler.
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
`define TCC_OFF_CTRL    12'h000
`define TCC_OFF_COUNT   12'h004
`define TCC_OFF_CMP     12'h008
`define TCC_OFF_FLAG    12'h00C
`define TCC_OFF_MASK    12'h010
`define TCC_OFF_FORCE   12'h014
`define TCC_F_WGM_LO    0
`define TCC_F_WGM_HI    2
`define TCC_F_COM_LO    4
`define TCC_F_CS_LO     8
`define TCC_BIT_OVF     0
`define TCC_BIT_CMP     1
`define TCC_BIT_FORCE   0
`define TCC_BOTTOM      8'h00
`define TCC_MAX         8'hFF
`define TCC_RST_BYTE    8'h00
`endif

// ==== tcc_pkg.sv ====
// Purpose: types for the timer/counter
// Assumes: nothing
// Notes:   mode codes follow the waveform-mode field
package tcc_pkg;
   typedef enum logic [2:0] {
      TCC_NORMAL = 3'h0,
      TCC_PCPWM  = 3'h1,
      TCC_CTC    = 3'h2,
      TCC_FPWM   = 3'h3,
      TCC_RSV4   = 3'h4,
      TCC_PCPWM_T = 3'h5,
      TCC_RSV6   = 3'h6,
      TCC_FPWM_T = 3'h7
   } tcc_mode_t;
   typedef enum {TCC_UP, TCC_DOWN} tcc_dir_t;
endpackage

// ==== tcc_sync.sv ====
// Purpose: three-stage synchroniser for a pin-side level
// Assumes: input is asynchronous to pclk
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module tcc_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic din,
   output logic      dout
);
   logic s1;
   logic s2;
   logic s3;
   // Shift chain, first stage read only by the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1   <= 1'b0;
         s2   <= 1'b0;
         s3   <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            dout <= s3;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tcc_wavegen.sv ====
// Purpose: compare output state machine
// Assumes: match and force already qualified by the caller
// Notes:   action bits act at once on the next event
`timescale 1ns/1ps
`default_nettype none
module tcc_wavegen
   import tcc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       tick,
   input  wire logic       match,
   input  wire logic       force_hit,
   input  wire logic       at_top,
   input  wire logic       at_bottom,
   input  wire logic       down,
   input  wire logic [2:0] mode,
   input  wire logic [1:0] action,
   output logic            oc_state
);
   logic next_oc;
   logic pwm;
   logic slope;

   // Next output value from event, mode and action
   always_comb begin
      pwm     = (mode[0] == 1'b1);
      slope   = (mode[1:0] == 2'b11);
      next_oc = oc_state;
      if (!pwm) begin
         if ((tick && match) || force_hit) begin            // [RULE_19]
            unique case (action)                           // [RULE_20]
               2'b00: next_oc = oc_state;
               2'b01: next_oc = ~oc_state;
               2'b10: next_oc = 1'b0;
               2'b11: next_oc = 1'b1;
            endcase
         end
      end else if (action[1] && tick) begin                 // [RULE_15]
         if (slope) begin
            if (at_bottom) begin
               next_oc = ~action[0];
            end else if (match) begin
               next_oc = action[0];
            end
         end else if (match) begin
            next_oc = down ? ~action[0] : action[0];
         end else if (at_top && !match) begin
            next_oc = next_oc;
         end
      end
   end

   // Output state register, held across mode changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oc_state <= 1'b0;                                 // [RULE_27]
      end else begin
         oc_state <= next_oc;                              // [RULE_22]
      end
   end
endmodule
`default_nettype wire

// ==== tcc_timer_props.sv ====
// Purpose: port assertions for the timer/counter
// Assumes: pin clock edges never move the counter onto top or bottom
// Notes:   bound to tcc_timer below the module
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [6:0]  presc_tick,
   input wire logic        cmp_irq_ack,
   input wire logic        ovf_irq_ack,
   input wire logic        ovf_irq,
   input wire logic        cmp_irq,
   input wire logic        top_flag,
   input wire logic        bottom_flag
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Access phase, and a span with no tick and no bus traffic
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_quiet;
      (presc_tick == 7'h00 && !psel)[*3];
   endsequence
   // Bus answers
   a_ready_in_access: assert property (s_access |-> pready)
      else $error("no pready in access phase");
   a_err_unmapped: assert property
      (psel && penable && paddr > 12'h014 |-> pslverr)
      else $error("no error on unmapped address");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without pready");
   a_read_upper_zero: assert property
      (pready && !pwrite |-> prdata[31:11] == 21'h0)
      else $error("upper read bits not zero");
   // No tick, no write: counter flags hold
   a_stopped_stable: assert property
      (s_quiet |=> $stable(top_flag) && $stable(bottom_flag))
      else $error("flags moved while stopped");
   // Service acknowledge drops the request two cycles on
   a_cmp_ack_clears: assert property
      (cmp_irq_ack && presc_tick == 7'h00 |-> ##2 !cmp_irq)
      else $error("compare request survived acknowledge");
   a_ovf_ack_clears: assert property
      (ovf_irq_ack && presc_tick == 7'h00 |-> ##2 !ovf_irq)
      else $error("overflow request survived acknowledge");
   // A pending request holds until cleared
   a_cmp_irq_holds: assert property
      (cmp_irq && !cmp_irq_ack && !$past(cmp_irq_ack) && !psel
       && !$past(psel) |=> cmp_irq)
      else $error("compare request dropped by itself");
endmodule
bind tcc_timer tcc_timer_props u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .presc_tick(presc_tick), .cmp_irq_ack(cmp_irq_ack),
   .ovf_irq_ack(ovf_irq_ack), .ovf_irq(ovf_irq), .cmp_irq(cmp_irq),
   .top_flag(top_flag), .bottom_flag(bottom_flag));
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: directed register tests of the timer/counter
// Assumes: clock select 1 ticks from presc_tick[1]
// Notes:   pin clock driven only in the last test
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.svh"
module tb_top;
   localparam logic [11:0] r_ctl = `TCC_OFF_CTRL;
   localparam logic [11:0] r_cnt = `TCC_OFF_COUNT;
   localparam logic [11:0] r_cmp = `TCC_OFF_CMP;
   localparam logic [11:0] r_flg = `TCC_OFF_FLAG;
   localparam logic [11:0] r_msk = `TCC_OFF_MASK;
   localparam logic [11:0] r_frc = `TCC_OFF_FORCE;
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [6:0]  presc_tick = 7'h00;
   logic        ext_clk_pin = 1'h0;
   logic        cmp_irq_ack = 1'h0;
   logic        ovf_irq_ack = 1'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, ovf_irq, cmp_irq;
   logic        compare_output, top_flag, bottom_flag;
   logic [31:0] rdv;
   logic        lerr;
   logic        oc_exp;
   logic [1:0]  acts [4] = '{2'h1, 2'h3, 2'h2, 2'h1};
   int          num_errors = 0;
   int          n_tests = 0;

   // 25 MHz clock
   always #20 pclk = ~pclk;

   tcc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .presc_tick(presc_tick), .ext_clk_pin(ext_clk_pin),
      .cmp_irq_ack(cmp_irq_ack), .ovf_irq_ack(ovf_irq_ack),
      .ovf_irq(ovf_irq), .cmp_irq(cmp_irq), .compare_output(compare_output),
      .top_flag(top_flag), .bottom_flag(bottom_flag));

   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e,
                      input string m);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask

   // One APB transfer, entered just after a rising edge
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      chk(32'(n < 50), 32'h1, "pready wait");
      rdv = prdata;
      lerr = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'h1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input string m);
      xfer(1'h0, a, 32'h0);
      chk(rdv, e, m);
   endtask

   // One-cycle timer ticks on the select-1 input
   task automatic tick(input int n);
      repeat (n) begin
         presc_tick <= 7'h02;
         @(posedge pclk);
         presc_tick <= 7'h00;
         @(posedge pclk);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // Control word: mode, output action, clock select
   function automatic logic [31:0] ctl(input logic [2:0] m,
      input logic [1:0] c, input logic [2:0] s);
      return {21'h0, s, 2'h0, c, 1'h0, m};
   endfunction

   // Verdict
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      idle(6000);
      num_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      conclude();
   end

   // Test sequence
   initial begin
      idle(20);
      presetn <= 1'h1;
      @(posedge pclk);
      chk(32'(compare_output), 32'h0, "output reset");
      rd(r_cnt, 32'h0, "count reset");
      rd(r_flg, 32'h0, "flag reset");
      wr(r_cnt, 32'h5A);
      rd(r_cnt, 32'h5A, "count rw");
      xfer(1'h0, 12'h018, 32'h0);
      chk(32'(lerr), 32'h1, "unmapped");
      $display("test registers done");
      wr(r_ctl, ctl(3'h0, 2'h0, 3'h0));
      wr(r_cnt, 32'h33);
      presc_tick <= 7'h7E;
      idle(4);
      presc_tick <= 7'h00;
      rd(r_cnt, 32'h33, "stopped");
      $display("test stopped done");
      wr(r_msk, 32'h1);
      wr(r_ctl, ctl(3'h0, 2'h0, 3'h1));
      wr(r_cnt, 32'hFE);
      tick(1);
      rd(r_cnt, 32'hFF, "count max");
      chk(32'(top_flag), 32'h1, "top at max");
      tick(1);
      rd(r_cnt, 32'h0, "wrap");
      rd(r_flg, 32'h1, "overflow");
      chk(32'(bottom_flag), 32'h1, "bottom");
      chk(32'(ovf_irq), 32'h1, "ovf irq");
      ovf_irq_ack <= 1'h1;
      @(posedge pclk);
      ovf_irq_ack <= 1'h0;
      idle(2);
      chk(32'(ovf_irq), 32'h0, "ovf ack");
      rd(r_flg, 32'h0, "ovf cleared");
      $display("test overflow done");
      wr(r_cmp, 32'h10);
      rd(r_cmp, 32'h10, "direct cmp");
      wr(r_cnt, 32'h0F);
      tick(1);
      rd(r_flg, 32'h0, "no flag yet");
      tick(1);
      rd(r_flg, 32'h2, "match flag");
      wr(r_flg, 32'h0);
      rd(r_flg, 32'h2, "zero keeps");
      wr(r_flg, 32'h2);
      rd(r_flg, 32'h0, "one clears");
      wr(r_cnt, 32'h10);
      tick(1);
      rd(r_flg, 32'h0, "blocked match");
      presc_tick <= 7'h02;
      wr(r_cnt, 32'h80);
      presc_tick <= 7'h00;
      rd(r_cnt, 32'h81, "write wins");
      $display("test compare done");
      wr(r_msk, 32'h2);
      wr(r_cnt, 32'h0F);
      tick(2);
      idle(2);
      chk(32'(cmp_irq), 32'h1, "cmp irq");
      cmp_irq_ack <= 1'h1;
      @(posedge pclk);
      cmp_irq_ack <= 1'h0;
      idle(2);
      chk(32'(cmp_irq), 32'h0, "cmp ack");
      rd(r_flg, 32'h0, "cmp serviced");
      $display("test interrupt done");
      wr(r_ctl, ctl(3'h2, 2'h1, 3'h0));
      wr(r_cmp, 32'h3);
      wr(r_cnt, 32'h1);
      wr(r_ctl, ctl(3'h2, 2'h1, 3'h1));
      tick(3);
      rd(r_cnt, 32'h0, "match clear");
      rd(r_flg, 32'h2, "match flag");
      chk(32'(compare_output), 32'h1, "toggle");
      wr(r_flg, 32'h2);
      $display("test clear on match done");
      wr(r_cnt, 32'h3);
      oc_exp = 1'h1;
      for (int i = 0; i < 4; i++) begin
         wr(r_ctl, ctl(3'h0, acts[i], 3'h0));
         wr(r_frc, 32'h1);
         idle(2);
         oc_exp = (acts[i] == 2'h1) ? ~oc_exp : (acts[i] == 2'h3);
         chk(32'(compare_output), 32'(oc_exp), "forced");
      end
      rd(r_cnt, 32'h3, "force no clear");
      rd(r_flg, 32'h0, "force no flag");
      wr(r_ctl, ctl(3'h3, 2'h0, 3'h0));
      idle(2);
      chk(32'(compare_output), 32'h1, "mode change");
      $display("test force done");
      wr(r_ctl, ctl(3'h1, 2'h0, 3'h1));
      wr(r_cnt, 32'hFE);
      tick(2);
      rd(r_cnt, 32'hFE, "down count");
      wr(r_ctl, ctl(3'h0, 2'h0, 3'h0));
      wr(r_cmp, 32'h6);
      wr(r_ctl, ctl(3'h7, 2'h0, 3'h0));
      wr(r_cmp, 32'h9);
      wr(r_ctl, ctl(3'h7, 2'h0, 3'h1));
      wr(r_cnt, 32'h5);
      tick(1);
      idle(2);
      chk(32'(top_flag), 32'h1, "old top");
      rd(r_cmp, 32'h9, "buffer read");
      tick(1);
      rd(r_cnt, 32'h0, "clear at top");
      wr(r_ctl, ctl(3'h7, 2'h0, 3'h0));
      wr(r_cnt, 32'h6);
      idle(2);
      chk(32'(top_flag), 32'h0, "top moved");
      wr(r_cnt, 32'h9);
      idle(2);
      chk(32'(top_flag), 32'h1, "new top");
      $display("test pwm buffer done");
      // Pin clock: select 7 counts rising edges, select 6 falling ones
      wr(r_ctl, ctl(3'h0, 2'h0, 3'h7));
      wr(r_cnt, 32'h20);
      ext_clk_pin <= 1'h1;
      idle(8);
      ext_clk_pin <= 1'h0;
      idle(8);
      rd(r_cnt, 32'h21, "rising edge");
      wr(r_ctl, ctl(3'h0, 2'h0, 3'h6));
      ext_clk_pin <= 1'h1;
      idle(8);
      ext_clk_pin <= 1'h0;
      idle(8);
      rd(r_cnt, 32'h22, "falling edge");
      $display("test pin clock done");
      conclude();
   end
endmodule
`default_nettype wire
